/* hw/pmw_sequencer.sv */
// Operating-mode, halt and wake-up clock sequencer.
// Behaviour
// - Fast wake-up follows fast_wake_enable bit.
// - Fast wake only from sub-clock-alive stop states.
// - Crystal: run sub clock until 1024 cycles.
// - RC sources wait 15 or 1 cycles.
// - Deep stop (watchdog and detector off) means no fast wake.
// - Mode select bits switch; halt enters sleep.
// - Halt target from idle_select and idle_sysclk_keep.
// - Low clock use stops high oscillator, dividers.
// - Slow mode: select 0, divider 000/001.
// - Slow switch waits low oscillator ready flag.
// - Normal mode for other selections.
// - Halt, no watchdog or detector: deep stop.
// - Deep stop halts system, watchdog, time-base.
// - Deep stop clears then stops watchdog.
// - Sleep keeps memory, registers, port states.
// - Sleep sets power-down, clears timeout flag.
// - Halt with watchdog or detector: keep sub.
// - Keep-sub stop runs watchdog from sub clock.
// - Keep-sub entry clears, then continues watchdog.
// - Idle keeps or stops system clock.
// - High ready cleared at reset and stops.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pmw_sequencer #(
	parameter pmw_pkg::pmw_src_t SYS_SRC = pmw_pkg::PMW_SRC_XTAL
) (
	input  wire logic                   ref_clk,      // 125 MHz clock
	input  wire logic                   rst,          // synchronous reset, high
	input  wire logic [3:0]             reg_addr,     // register address
	input  wire logic [7:0]             reg_wdata,    // write data
	input  wire logic                   reg_wr,       // write strobe
	input  wire logic                   reg_rd,       // read strobe
	output logic      [7:0]             reg_rdata,    // read data, cycle after strobe
	input  wire logic                   halt_exec,    // halt instruction pulse from core
	input  wire logic                   wake_req,     // wake-up request level from core
	input  wire logic                   wd_timeout,   // watchdog time-out pulse
	input  wire logic                   hs_osc_tick,  // high-speed oscillator edge, from pin domain
	input  wire logic                   ls_osc_tick,  // low-speed oscillator edge, from pin domain
	output pmw_pkg::pmw_clk_ctrl_t      clk_ctrl,     // clock gating and selection controls
	output logic                        slow_mode,    // system clock taken from low clock
	output logic [2:0]                  power_state   // present power state code
);
	typedef struct packed {
		logic [7:0]          mode;
		logic [7:0]          wdctrl;
		logic                pd_flag;
		logic                to_flag;
		pmw_pkg::pmw_state_t st;
		logic [10:0]         cnt;
		logic                cnt_hs;
		logic                ls_ready;
		logic                slow_on;
		logic [7:0]          rdata;
		pmw_pkg::pmw_clk_ctrl_t ctrl;
		logic [1:0]          hs_sync;
		logic [1:0]          ls_sync;
		logic                hs_prev;
		logic                ls_prev;
	} pmw_state_reg_t;

	pmw_state_reg_t s;
	pmw_state_reg_t next_s;

	logic hs_edge;
	logic ls_edge;
	logic div_low;
	logic want_slow;
	logic wd_or_lvdet;
	logic [10:0] hs_start_cnt;
	logic fast_ok;
	logic cnt_tick;
	logic cnt_done;

	always_comb begin
		hs_edge   = s.hs_sync[1] & ~s.hs_prev;
		ls_edge   = s.ls_sync[1] & ~s.ls_prev;
		div_low   = (s.mode[pmw_pkg::MODE_DIV_LSB +: 3] == pmw_pkg::DIV_LOW_A) ||
		            (s.mode[pmw_pkg::MODE_DIV_LSB +: 3] == pmw_pkg::DIV_LOW_B);
		want_slow = ~s.mode[pmw_pkg::MODE_HSSEL_BIT] & div_low;
		wd_or_lvdet = s.wdctrl[pmw_pkg::WD_EN_BIT] | s.wdctrl[pmw_pkg::WD_LVDET_BIT];
		// Sub clock only survives in stop-keep-sub and idle-sub states.
		fast_ok   = s.mode[pmw_pkg::MODE_FAST_BIT] && SYS_SRC == pmw_pkg::PMW_SRC_XTAL &&
		            (s.st == pmw_pkg::PMW_STOP_SUB || s.st == pmw_pkg::PMW_IDLE_SUB);
		cnt_tick  = s.cnt_hs ? hs_edge : ls_edge;
		cnt_done  = cnt_tick && (s.cnt == 11'h001);
	end

	// Start-up wait of the high-speed source in its own cycles; shared by wake-up and the return from slow mode.
	always_comb begin
		case (SYS_SRC)
			pmw_pkg::PMW_SRC_XTAL:  hs_start_cnt = pmw_pkg::XTAL_START_CYC;
			pmw_pkg::PMW_SRC_LS_RC: hs_start_cnt = pmw_pkg::LSRC_START_CYC;
			default:                hs_start_cnt = pmw_pkg::RC_START_CYC;
		endcase
	end

	always_comb begin
		next_s = s;
		next_s.hs_sync = {s.hs_sync[0], hs_osc_tick};
		next_s.ls_sync = {s.ls_sync[0], ls_osc_tick};
		next_s.hs_prev = s.hs_sync[1];
		next_s.ls_prev = s.ls_sync[1];
		next_s.rdata   = 8'h00;
		next_s.ctrl.wd_clear = 1'b0;
		if (cnt_tick && s.cnt != 11'h000) begin
			next_s.cnt = s.cnt - 11'h001;
		end
		if (wd_timeout) begin
			next_s.to_flag = 1'b1;
		end

		if (reg_wr) begin
			case (reg_addr)
				pmw_pkg::ADDR_MODE: begin
					// Ready flags are hardware owned; software writes are dropped there.
					next_s.mode = {reg_wdata[7:4], s.mode[pmw_pkg::MODE_LSRDY_BIT],
					               s.mode[pmw_pkg::MODE_HSRDY_BIT], reg_wdata[1:0]};
				end
				pmw_pkg::ADDR_WDCTRL: begin
					next_s.wdctrl = {4'h0, reg_wdata[3:0]};
				end
				pmw_pkg::ADDR_STATUS: begin
					// Clearing the power-down flag mirrors the clear-watchdog instruction.
					if (reg_wdata[pmw_pkg::ST_PD_BIT]) begin
						next_s.pd_flag = 1'b0;
					end
					if (reg_wdata[pmw_pkg::ST_TMO_BIT] && !wd_timeout) begin
						next_s.to_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				pmw_pkg::ADDR_MODE:   next_s.rdata = s.mode;
				pmw_pkg::ADDR_WDCTRL: next_s.rdata = s.wdctrl;
				pmw_pkg::ADDR_STATUS: next_s.rdata = {6'h00, s.to_flag, s.pd_flag};
				pmw_pkg::ADDR_STATE:  next_s.rdata = {5'h00, s.st};
				default:              next_s.rdata = 8'h00;
			endcase
		end

		case (s.st)
			pmw_pkg::PMW_RUN: begin
				// Slow/normal switching in run; low clock only once stable.
				if (want_slow) begin
					// A finished high-speed wait leaves cnt_hs set, so the counter is free then too.
					if (!s.ls_ready && (s.cnt_hs || s.cnt == 11'h000)) begin
						next_s.cnt = pmw_pkg::XTAL_START_CYC;
						next_s.cnt_hs = 1'b0;
					end
					if ((cnt_done && !s.cnt_hs) || s.ls_ready) begin
						next_s.ls_ready = 1'b1;
						next_s.mode[pmw_pkg::MODE_LSRDY_BIT] = 1'b1;
						next_s.slow_on = 1'b1;
						next_s.ctrl.sys_on_sub = 1'b1;
						next_s.ctrl.hs_osc_en  = 1'b0;
						next_s.ctrl.hs_div_en  = 1'b0;
						next_s.mode[pmw_pkg::MODE_HSRDY_BIT] = 1'b0;
					end
				end else if (s.slow_on) begin
					// Back to normal: restart high oscillator, stay on sub clock until ready.
					if (!s.ctrl.hs_osc_en) begin
						next_s.ctrl.hs_osc_en = 1'b1;
						next_s.cnt    = hs_start_cnt;
						next_s.cnt_hs = 1'b1;
					end else if (cnt_done) begin
						next_s.mode[pmw_pkg::MODE_HSRDY_BIT] = 1'b1;
						next_s.ctrl.hs_div_en  = 1'b1;
						next_s.ctrl.sys_on_sub = 1'b0;
						next_s.slow_on = 1'b0;
					end
				end
				if (halt_exec) begin
					next_s.pd_flag = 1'b1;
					// A time-out in the halt cycle still wins over the clear.
					next_s.to_flag = wd_timeout;
					next_s.ctrl.cpu_run   = 1'b0;
					next_s.ctrl.wd_clear  = 1'b1;
					next_s.ctrl.tb_en     = 1'b0;
					if (s.mode[pmw_pkg::MODE_IDLE_BIT]) begin
						next_s.ctrl.tb_en = 1'b1;
						if (s.wdctrl[pmw_pkg::WD_KEEP_BIT]) begin
							next_s.st = pmw_pkg::PMW_IDLE_RUN;
						end else begin
							next_s.st = pmw_pkg::PMW_IDLE_SUB;
							next_s.ctrl.sys_en = 1'b0;
						end
					end else if (wd_or_lvdet) begin
						next_s.st = pmw_pkg::PMW_STOP_SUB;
						next_s.ctrl.sys_en = 1'b0;
						next_s.ctrl.wd_en  = s.wdctrl[pmw_pkg::WD_EN_BIT] & s.wdctrl[pmw_pkg::WD_SUB_BIT];
					end else begin
						next_s.st = pmw_pkg::PMW_DEEP_STOP;
						next_s.ctrl.sys_en = 1'b0;
						next_s.ctrl.wd_en  = 1'b0;
						next_s.ls_ready = 1'b0;
						next_s.mode[pmw_pkg::MODE_LSRDY_BIT] = 1'b0;
					end
					if (!s.mode[pmw_pkg::MODE_IDLE_BIT] || !s.wdctrl[pmw_pkg::WD_KEEP_BIT]) begin
						next_s.ctrl.hs_osc_en = 1'b0;
						next_s.ctrl.hs_div_en = 1'b0;
						next_s.mode[pmw_pkg::MODE_HSRDY_BIT] = 1'b0;
					end
				end
			end
			pmw_pkg::PMW_IDLE_RUN: begin
				if (wake_req) begin
					next_s.st = pmw_pkg::PMW_RUN;
					next_s.ctrl.cpu_run = 1'b1;
				end
			end
			pmw_pkg::PMW_DEEP_STOP, pmw_pkg::PMW_STOP_SUB, pmw_pkg::PMW_IDLE_SUB: begin
				// Memory, registers and ports are frozen simply by holding cpu_run low.
				if (wake_req) begin
					next_s.ctrl.tb_en = 1'b1;
					if (s.slow_on) begin
						next_s.st   = pmw_pkg::PMW_WAKE_WAIT;
						next_s.cnt  = pmw_pkg::SUB_WAKE_CYC;
						next_s.cnt_hs = 1'b0;
					end else begin
						next_s.ctrl.hs_osc_en = 1'b1;
						next_s.cnt_hs = 1'b1;
						next_s.cnt = hs_start_cnt;
						if (fast_ok) begin
							next_s.st = pmw_pkg::PMW_FAST_RUN;
							next_s.ctrl.sys_on_sub = 1'b1;
							next_s.ctrl.sys_en     = 1'b1;
							next_s.ctrl.cpu_run    = 1'b1;
						end else begin
							next_s.st = pmw_pkg::PMW_WAKE_WAIT;
						end
					end
					next_s.ctrl.wd_en = s.wdctrl[pmw_pkg::WD_EN_BIT];
				end
			end
			pmw_pkg::PMW_WAKE_WAIT: begin
				if (cnt_done) begin
					next_s.st = pmw_pkg::PMW_RUN;
					next_s.ctrl.sys_en  = 1'b1;
					next_s.ctrl.cpu_run = 1'b1;
					if (!s.slow_on) begin
						next_s.ctrl.hs_div_en = 1'b1;
						next_s.ctrl.sys_on_sub = 1'b0;
						next_s.mode[pmw_pkg::MODE_HSRDY_BIT] = 1'b1;
					end
				end
			end
			pmw_pkg::PMW_FAST_RUN: begin
				if (cnt_done) begin
					// The gating cell swaps sources only on a low phase of both clocks.
					next_s.st = pmw_pkg::PMW_RUN;
					next_s.ctrl.sys_on_sub = 1'b0;
					next_s.ctrl.hs_div_en  = 1'b1;
					next_s.mode[pmw_pkg::MODE_HSRDY_BIT] = 1'b1;
				end
			end
			default: begin
				next_s.st = pmw_pkg::PMW_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s <= '0;
			s.mode   <= pmw_pkg::MODE_RESET;
			s.wdctrl <= pmw_pkg::WDCTRL_RESET;
			s.st     <= pmw_pkg::PMW_WAKE_WAIT;
			s.cnt    <= pmw_pkg::XTAL_START_CYC;
			s.cnt_hs <= 1'b1;
			s.ctrl   <= '{sys_en: 1'b0, sys_on_sub: 1'b0, hs_osc_en: 1'b1, hs_div_en: 1'b0,
			              tb_en: 1'b1, wd_en: 1'b0, wd_clear: 1'b0, cpu_run: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		reg_rdata   = s.rdata;
		clk_ctrl    = s.ctrl;
		slow_mode   = s.slow_on;
		power_state = s.st;
	end
endmodule
`default_nettype wire

/* include/pmw_pkg.sv */
// Package with constants, encodings and carrier types of the power mode and wake-up sequencer.
`default_nettype none
package pmw_pkg;
	// Register offsets of the plain register port.
	localparam logic [3:0] ADDR_MODE   = 4'h0;
	localparam logic [3:0] ADDR_WDCTRL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_STATE  = 4'h3;
	// Mode register field positions.
	localparam int MODE_DIV_LSB   = 5;
	localparam int MODE_FAST_BIT  = 4;
	localparam int MODE_LSRDY_BIT = 3;
	localparam int MODE_HSRDY_BIT = 2;
	localparam int MODE_IDLE_BIT  = 1;
	localparam int MODE_HSSEL_BIT = 0;
	// Watchdog control and status field positions.
	localparam int WD_KEEP_BIT = 0;
	localparam int WD_EN_BIT   = 1;
	localparam int WD_SUB_BIT  = 2;
	localparam int WD_LVDET_BIT = 3;
	localparam int ST_PD_BIT    = 0;
	localparam int ST_TMO_BIT   = 1;
	// Reset values.
	localparam logic [7:0] MODE_RESET   = 8'h01;
	localparam logic [7:0] WDCTRL_RESET = 8'h00;
	// Divider codes that select the low-speed clock.
	localparam logic [2:0] DIV_LOW_A = 3'h0;
	localparam logic [2:0] DIV_LOW_B = 3'h1;
	// Start-up counts in oscillator cycles.
	localparam logic [10:0] XTAL_START_CYC = 11'h400;
	localparam logic [10:0] RC_START_CYC   = 11'h00F;
	localparam logic [10:0] LSRC_START_CYC = 11'h001;
	localparam logic [10:0] SUB_WAKE_CYC   = 11'h001;

	typedef enum logic [1:0] {
		PMW_SRC_XTAL = 2'b00,
		PMW_SRC_EXT_RC = 2'b01,
		PMW_SRC_HS_RC  = 2'b10,
		PMW_SRC_LS_RC  = 2'b11
	} pmw_src_t;

	typedef enum logic [2:0] {
		PMW_RUN        = 3'b000,
		PMW_DEEP_STOP  = 3'b001,
		PMW_STOP_SUB   = 3'b010,
		PMW_IDLE_SUB   = 3'b011,
		PMW_IDLE_RUN   = 3'b100,
		PMW_WAKE_WAIT  = 3'b101,
		PMW_FAST_RUN   = 3'b110
	} pmw_state_t;

	typedef struct packed {
		logic sys_en;
		logic sys_on_sub;
		logic hs_osc_en;
		logic hs_div_en;
		logic tb_en;
		logic wd_en;
		logic wd_clear;
		logic cpu_run;
	} pmw_clk_ctrl_t;
endpackage
`default_nettype wire

/* tb/pmw_osc_model.sv */
// Behavioural model of the high-speed and low-speed oscillators that feed the sequencer.
`timescale 1ns/1ps
`default_nettype none
module pmw_osc_model (
	input  wire logic ref_clk, // bench clock
	input  wire logic hs_en,   // high-speed oscillator enable
	output logic      hs_tick, // high-speed oscillator pin
	output logic      ls_tick  // low-speed oscillator pin
);
	logic [1:0] ls_div = 2'h0;
	initial hs_tick = 1'b0;
	initial ls_tick = 1'b0;
	// A stopped oscillator holds its pin low, so no stray edge can be counted.
	always @(posedge ref_clk) begin
		hs_tick <= (hs_en === 1'b1) ? ~hs_tick : 1'b0;
		ls_div <= (ls_div == 2'h2) ? 2'h0 : ls_div + 2'h1;
		if (ls_div == 2'h2) begin
			ls_tick <= ~ls_tick;
		end
	end
endmodule
`default_nettype wire

/* tb/pmw_seq_checker.sv */
// Concurrent checks on the ports of the power mode and wake-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module pmw_seq_checker (
	input wire logic                   ref_clk,     // clock
	input wire logic                   rst,         // reset, high
	input wire logic                   reg_rd,      // read strobe
	input wire logic [7:0]             reg_rdata,   // read data
	input wire logic                   halt_exec,   // halt pulse
	input wire pmw_pkg::pmw_clk_ctrl_t clk_ctrl,    // clock controls
	input wire logic                   slow_mode,   // slow mode level
	input wire logic [2:0]             power_state  // state code
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_deep_stop_clocks: assert property (power_state == 3'h1 |->
		!clk_ctrl.sys_en && !clk_ctrl.wd_en && !clk_ctrl.tb_en && !clk_ctrl.cpu_run)
		else $error("deep stop left a clock running");
	a_keep_sub_clocks: assert property (power_state == 3'h2 |->
		!clk_ctrl.sys_en && !clk_ctrl.tb_en && !clk_ctrl.cpu_run)
		else $error("keep-sub stop left the system clock running");
	a_idle_run_clock: assert property (power_state == 3'h4 |-> clk_ctrl.sys_en && !clk_ctrl.cpu_run)
		else $error("idle with clock kept has wrong clocks");
	a_halt_enters_sleep: assert property (halt_exec && power_state == 3'h0 |=>
		power_state inside {[3'h1:3'h4]} && clk_ctrl.wd_clear)
		else $error("halt did not enter a sleep state");
	a_sleep_only_halt: assert property (power_state == 3'h0 && !halt_exec |=>
		!(power_state inside {[3'h1:3'h4]}))
		else $error("sleep entered without halt");
	a_clear_one_cycle: assert property (clk_ctrl.wd_clear |=> !clk_ctrl.wd_clear)
		else $error("watchdog clear longer than one cycle");
	a_deep_no_fast: assert property (power_state == 3'h1 |=> power_state != 3'h6)
		else $error("fast wake from deep stop");
	a_fast_on_sub: assert property (power_state == 3'h6 |-> clk_ctrl.sys_on_sub && clk_ctrl.cpu_run)
		else $error("fast run not on sub clock");
	a_slow_hs_off: assert property (slow_mode |-> !clk_ctrl.hs_div_en &&
		(!$rose(slow_mode) || !clk_ctrl.hs_osc_en))
		else $error("high oscillator running on entry to slow mode");
	a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without strobe");
	c_deep: cover property (power_state == 3'h1);
	c_fast: cover property (power_state == 3'h6);
	c_slow: cover property ($rose(slow_mode));
endmodule
bind pmw_sequencer pmw_seq_checker chk_u (.ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.halt_exec(halt_exec), .clk_ctrl(clk_ctrl), .slow_mode(slow_mode), .power_state(power_state));
`default_nettype wire

/* tb/pmw_sequencer_test.sv */
// Self-checking testbench of the power mode and wake-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module pmw_sequencer_test;
	logic                   ref_clk = 1'b0;
	logic                   rst = 1'b1;
	logic [3:0]             reg_addr = 4'h0;
	logic [7:0]             reg_wdata = 8'h00;
	logic                   reg_wr = 1'b0;
	logic                   reg_rd = 1'b0;
	logic                   halt_exec = 1'b0;
	logic                   wake_req = 1'b0;
	logic                   wd_timeout = 1'b0;
	logic [7:0]             reg_rdata;
	logic                   hs_tick;
	logic                   ls_tick;
	pmw_pkg::pmw_clk_ctrl_t clk_ctrl;
	logic                   slow_mode;
	logic [2:0]             power_state;
	logic [7:0]             d;
	int                     n_errors = 0;
	int                     check_count = 0;
	always #4 ref_clk = ~ref_clk;
	pmw_osc_model osc_u (.ref_clk(ref_clk), .hs_en(clk_ctrl.hs_osc_en), .hs_tick(hs_tick), .ls_tick(ls_tick));
	pmw_sequencer dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec), .wake_req(wake_req), .wd_timeout(wd_timeout),
		.hs_osc_tick(hs_tick), .ls_osc_tick(ls_tick), .clk_ctrl(clk_ctrl), .slow_mode(slow_mode),
		.power_state(power_state));
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pulse(input int sel);
		@(posedge ref_clk);
		halt_exec <= (sel == 0);
		wake_req <= (sel == 1);
		wd_timeout <= (sel == 2);
		@(posedge ref_clk);
		halt_exec <= 1'b0;
		wake_req <= 1'b0;
		wd_timeout <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Waits are bounded; a state that never arrives ends the run at once.
	task automatic wait_st(input logic [2:0] s, input logic sl);
		for (int i = 0; i < 8000 && (power_state !== s || slow_mode !== sl); i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk({4'h0, slow_mode, power_state}, {4'h0, sl, s});
		if (power_state !== s || slow_mode !== sl) begin
			end_of_test();
		end
	endtask
	task automatic halt_wake(input logic [7:0] mode, input logic [7:0] wdc, input logic [2:0] s, input logic [2:0] w);
		wr(pmw_pkg::ADDR_MODE, mode);
		wr(pmw_pkg::ADDR_WDCTRL, wdc);
		pulse(2);
		pulse(0);
		chk({5'h00, power_state}, {5'h00, s});
		chk({7'h00, clk_ctrl.wd_clear}, 8'h01);
		chk({7'h00, clk_ctrl.wd_en}, {7'h00, wdc[1] && s == 3'h2});
		chk({7'h00, clk_ctrl.sys_en}, {7'h00, s == 3'h4});
		rd(pmw_pkg::ADDR_STATUS);
		chk(d, 8'h01);
		rd(pmw_pkg::ADDR_MODE);
		chk(d & 8'hF7, (mode & 8'hF3) | ((s == 3'h4) ? 8'h04 : 8'h00));
		wr(pmw_pkg::ADDR_STATUS, 8'h03);
		pulse(1);
		chk({5'h00, power_state}, {5'h00, w});
		if (w == 3'h6) begin
			chk({6'h00, clk_ctrl.sys_on_sub, clk_ctrl.cpu_run}, 8'h03);
		end
		wait_st(3'h0, 1'b0);
		rd(pmw_pkg::ADDR_MODE);
		chk(d & 8'hF7, (mode & 8'hF3) | 8'h04);
	endtask
	task automatic s_slow(input logic [7:0] code);
		wr(pmw_pkg::ADDR_MODE, code);
		wait_st(3'h0, 1'b1);
		chk({6'h00, clk_ctrl.hs_osc_en, clk_ctrl.hs_div_en}, 8'h00);
		rd(pmw_pkg::ADDR_MODE);
		chk(d & 8'h0C, 8'h08);
		wr(pmw_pkg::ADDR_MODE, code | 8'h40);
		for (int i = 0; i < 3000 && d[2] !== 1'b1; i++) begin
			rd(pmw_pkg::ADDR_MODE);
		end
		chk({7'h00, d[2]}, 8'h01);
		wait_st(3'h0, 1'b0);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		wait_st(3'h0, 1'b0);
		rd(pmw_pkg::ADDR_MODE);
		chk(d & 8'hF7, 8'h05);
		rd(4'hF);
		chk(d, 8'h00);
		halt_wake(8'h11, 8'h00, 3'h1, 3'h5);
		halt_wake(8'h11, 8'h06, 3'h2, 3'h6);
		halt_wake(8'h01, 8'h08, 3'h2, 3'h5);
		halt_wake(8'h13, 8'h00, 3'h3, 3'h6);
		halt_wake(8'h03, 8'h01, 3'h4, 3'h0);
		s_slow(8'h00);
		s_slow(8'h20);
		end_of_test();
	end
endmodule
`default_nettype wire
